// ==== core/dhw_device.sv ====
// Overview of operation
// - write starts with address byte, acknowledged
// - pointer byte follows, also acknowledged
// - single update is four bytes then STOP
// - no STOP: pointer plus two data repeats
// - STOP anywhere ends sequence, back to idle
// - data byte select bits choose target register
// - pointer 0xFF starts burst at channel zero
// - burst writes each pair, pointer then advances
// - burst ends after channel 39, three-byte resumes
// - square-wave alternation unavailable during burst
// - interface select low enables parallel only
// - parallel strobes count only with select low
// - strobe rising edge latches address and word
// - select pins choose parallel destination register
// - every one of 40 channels addressable
// - parallel word straight binary, bit 11 MSB
// - four-wire port samples falling, shifts rising; no four-wire port is built here
// - host sends serial data MSB first
// - slave address 10101 plus two strap bits
// - two-wire active when both selects high
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "dhw_regs.svh"

module dhw_device (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// address straps
	input  wire logic        strapBitHi,
	input  wire logic        strapBitLo,
	// decoded writes
	output logic             wrStrobe,
	output logic [5:0]       wrChan,
	output logic [1:0]       wrTarget,
	output logic [11:0]      wrWord,
	// mode status
	output logic             burstActive,
	output logic             toggleOk,
	// link
	dhw_if.dev               link
);
	import dhw_pkg::*;

	dhw_pkg::dhw_dev_t  r;
	dhw_pkg::dhw_dev_t  next_r;
	dhw_pkg::dhw_pins_t pins;

	// -----------------------------------------------------------------
	// pin bundle
	// -----------------------------------------------------------------
	assign pins.scl = link.sclIn;
	assign pins.sda = link.sdaIn;
	assign pins.chipSelN = link.chipSelN;
	assign pins.writeStrobeN = link.writeStrobeN;
	assign pins.interfaceSelect = link.interfaceSelect;
	assign pins.protocolSelect = link.protocolSelect;
	assign pins.targetSelHi = link.targetSelHi;
	assign pins.targetSelLo = link.targetSelLo;
	assign pins.channelAddress = link.channelAddress;
	assign pins.parallelWord = link.parallelWord;

	// bits where the last two stages agree take the new level
	function automatic dhw_pins_t settle(input dhw_pins_t a, input dhw_pins_t b,
			input dhw_pins_t held);
		settle = (~(a ^ b) & b) | ((a ^ b) & held);
	endfunction : settle

	// -----------------------------------------------------------------
	// next state
	// -----------------------------------------------------------------
	always_comb begin
		dhw_pins_t f;
		dhw_pins_t o;
		logic      serEn;
		logic      startCond;
		logic      stopCond;
		logic      sclRise;
		logic      sclFall;
		logic      parEdge;
		next_r = r;
		next_r.s1 = pins;
		next_r.s2 = r.s1;
		next_r.s3 = r.s2;
		next_r.flt = settle(r.s2, r.s3, r.flt);
		next_r.old = r.flt;
		next_r.wrStrobe = 1'b0;
		f = r.flt;
		o = r.old;
		serEn = f.interfaceSelect & f.protocolSelect;
		startCond = o.scl & f.scl & o.sda & ~f.sda;
		stopCond = o.scl & f.scl & ~o.sda & f.sda;
		// input sampled on clock edges only; the four-wire port is not built here
		sclRise = ~o.scl & f.scl;
		sclFall = o.scl & ~f.scl;
		parEdge = ~f.chipSelN & ~o.writeStrobeN & f.writeStrobeN;

		// -------------------------------------------------------------
		// parallel port
		// -------------------------------------------------------------
		// parallel only while interface select is low
		if (!f.interfaceSelect && parEdge) begin
			// latch address and word on rising strobe
			next_r.wrStrobe = 1'b1;
			next_r.wrChan = f.channelAddress;
			// select pins pick the target register
			next_r.wrTarget = {f.targetSelHi, f.targetSelLo};
			// straight binary, bit 11 most significant
			next_r.wrWord = f.parallelWord;
		end

		// -------------------------------------------------------------
		// two-wire slave
		// -------------------------------------------------------------
		if (!serEn) begin
			next_r.state = DS_IDLE;
			next_r.sdaOe = 1'b0;
			next_r.burst = 1'b0;
		end else if (stopCond) begin
			next_r.state = DS_IDLE;
			next_r.sdaOe = 1'b0;
			next_r.burst = 1'b0;
		end else if (startCond) begin
			// a repeated start re-addresses, so a pending burst is dropped too
			next_r.state = DS_RECV;
			next_r.phase = PH_ADDR;
			next_r.bitCnt = 4'h0;
			next_r.sdaOe = 1'b0;
			next_r.burst = 1'b0;
		end else begin
			case (r.state)
				DS_RECV: begin
					if (sclRise) begin
						next_r.shift = {r.shift[6:0], f.sda};
						next_r.bitCnt = r.bitCnt + 4'h1;
					end else if (sclFall && r.bitCnt == `DHW_BYTE_BITS) begin
						next_r.bitCnt = 4'h0;
						next_r.state = DS_ACK;
						next_r.sdaOe = 1'b1;
						case (r.phase)
							PH_ADDR: begin
								if (r.shift[7:3] == `DHW_ADDR_FIXED &&
										r.shift[2:1] == {strapBitHi, strapBitLo} &&
										!r.shift[0]) begin
									next_r.phase = PH_PTR;
								end else begin
									next_r.state = DS_SKIP;
									next_r.sdaOe = 1'b0;
								end
							end
							PH_PTR: begin
								next_r.phase = PH_DHI;
								if (r.shift == `DHW_BURST_PTR) begin
									next_r.burst = 1'b1;
									next_r.chan = 6'h00;
								end else begin
									next_r.chan = r.shift[5:0];
								end
							end
							PH_DHI: begin
								next_r.hiByte = r.shift;
								next_r.phase = PH_DLO;
							end
							default: begin
								next_r.wrStrobe = 1'b1;
								next_r.wrChan = r.chan;
								// select bits in the first data byte
								next_r.wrTarget = {r.hiByte[`DHW_TSEL_HI_BIT],
									r.hiByte[`DHW_TSEL_LO_BIT]};
								next_r.wrWord = {r.hiByte[`DHW_WHI_MSB:0], r.shift};
								if (r.burst) begin
									// last channel returns to pointer framing
									if (r.chan == `DHW_LAST_CHAN) begin
										next_r.burst = 1'b0;
										next_r.phase = PH_PTR;
									end else begin
										next_r.chan = r.chan + 6'h01;
										next_r.phase = PH_DHI;
									end
								end else begin
									next_r.phase = PH_PTR;
								end
							end
						endcase
					end
				end
				DS_ACK: begin
					// the acknowledge is held for one whole clock-high period
					if (sclFall) begin
						next_r.sdaOe = 1'b0;
						next_r.state = DS_RECV;
					end
				end
				default: begin
					next_r.sdaOe = 1'b0;
				end
			endcase
		end

		next_r.toggleOk = ~next_r.burst;
	end

	// -----------------------------------------------------------------
	// registers
	// -----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			r <= '0;
			r.s1 <= '1;
			r.s2 <= '1;
			r.s3 <= '1;
			r.flt <= '1;
			r.old <= '1;
			r.state <= DS_IDLE;
			r.phase <= PH_ADDR;
			r.toggleOk <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	// -----------------------------------------------------------------
	// outputs
	// -----------------------------------------------------------------
	assign wrStrobe = r.wrStrobe;
	assign wrChan = r.wrChan;
	assign wrTarget = r.wrTarget;
	assign wrWord = r.wrWord;
	assign burstActive = r.burst;
	assign toggleOk = r.toggleOk;
	assign link.devSdaOut = 1'b0;
	assign link.devSdaOe = r.sdaOe;
endmodule : dhw_device

// ==== core/dhw_host.sv ====
`timescale 1ns/1ps
`include "dhw_regs.svh"

module dhw_host (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// link
	dhw_if.host              link
);
	import dhw_pkg::*;

	dhw_pkg::dhw_host_t r;
	dhw_pkg::dhw_host_t next_r;

	function automatic logic isMapped(input logic [11:0] a);
		isMapped = (a == `DHW_OFS_CMD) || (a == `DHW_OFS_PAR) ||
			(a == `DHW_OFS_STAT) || (a == `DHW_OFS_MODE);
	endfunction : isMapped

	// -----------------------------------------------------------------
	// next state
	// -----------------------------------------------------------------
	always_comb begin
		logic acc;
		logic done;
		logic tick;
		acc = psel & penable;
		done = acc & r.pready;
		tick = (r.qcnt == 8'h00);
		next_r = r;
		next_r.sdaSync = {r.sdaSync[2:0], link.sdaIn};
		// one wait state: read data is registered on the same edge that raises pready
		next_r.pready = acc & ~r.pready;
		if (acc & ~r.pready) begin
			next_r.pslverr = ~isMapped(paddr);
			next_r.prdata = 32'h0000_0000;
			if (paddr == `DHW_OFS_STAT) begin
				next_r.prdata[`DHW_STAT_BUSY] = (r.state != HS_IDLE);
				next_r.prdata[`DHW_STAT_NACK] = r.nack;
			end else if (paddr == `DHW_OFS_MODE) begin
				next_r.prdata[1:0] = r.mode;
			end
		end
		if (r.state != HS_IDLE)
			next_r.qcnt = tick ? 8'(`DHW_QTR_CYC - 1) : r.qcnt - 8'h01;
		case (r.state)
			HS_SLOT: begin
				if (tick) begin
					next_r.q = r.q + 2'h1;
					case (r.kind)
						SK_START: begin
							if (r.q == 2'h0)
								next_r.sclOe = 1'b0;
							else if (r.q == 2'h1)
								next_r.sdaOe = 1'b1;
							else if (r.q == 2'h2)
								next_r.sclOe = 1'b1;
							else begin
								next_r.kind = SK_BIT;
								next_r.sdaOe = ~r.shift[8];
							end
						end
						SK_BIT: begin
							if (r.q == 2'h0)
								next_r.sclOe = 1'b0;
							else if (r.q == 2'h1) begin
								// third and fourth stages agreeing mark a settled level
								if (r.bitIdx == 4'h8 && r.sdaSync[2] == r.sdaSync[3])
									next_r.nack = r.sdaSync[3];
							end else if (r.q == 2'h2)
								next_r.sclOe = 1'b1;
							else if (r.bitIdx == 4'h8) begin
								next_r.bitIdx = 4'h0;
								next_r.kind = SK_STOP;
								next_r.sdaOe = 1'b1;
								if (!r.doStop)
									next_r.state = HS_IDLE;
							end else begin
								next_r.bitIdx = r.bitIdx + 4'h1;
								next_r.shift = {r.shift[7:0], 1'b1};
								next_r.sdaOe = ~r.shift[7];
							end
						end
						default: begin
							if (r.q == 2'h0)
								next_r.sclOe = 1'b0;
							else if (r.q == 2'h1)
								next_r.sdaOe = 1'b0;
							else if (r.q == 2'h2)
								next_r.state = HS_IDLE;
						end
					endcase
				end
			end
			HS_PAR: begin
				if (tick) begin
					next_r.q = r.q + 2'h1;
					if (r.q == 2'h0)
						next_r.writeStrobeN = 1'b1;
					else begin
						next_r.chipSelN = 1'b1;
						next_r.state = HS_IDLE;
					end
				end
			end
			default: begin
				if (done && pwrite && paddr == `DHW_OFS_CMD) begin
					next_r.state = HS_SLOT;
					next_r.q = 2'h0;
					next_r.qcnt = 8'(`DHW_QTR_CYC - 1);
					next_r.bitIdx = 4'h0;
					next_r.nack = 1'b0;
					next_r.shift = {pwdata[7:0], 1'b1};
					next_r.doStop = pwdata[`DHW_CMD_STOP];
					next_r.kind = pwdata[`DHW_CMD_START] ? SK_START : SK_BIT;
					next_r.sdaOe = pwdata[`DHW_CMD_START] ? 1'b0 : ~pwdata[7];
				end else if (done && pwrite && paddr == `DHW_OFS_PAR) begin
					next_r.state = HS_PAR;
					next_r.q = 2'h0;
					next_r.qcnt = 8'(`DHW_PAR_CYC - 1);
					next_r.chipSelN = 1'b0;
					next_r.writeStrobeN = 1'b0;
					next_r.word = pwdata[11:0];
					next_r.chan = pwdata[`DHW_PAR_CHAN +: 6];
					next_r.tsel = pwdata[`DHW_PAR_TSEL +: 2];
				end else if (done && pwrite && paddr == `DHW_OFS_MODE) begin
					next_r.mode = pwdata[1:0];
				end
			end
		endcase
	end

	// -----------------------------------------------------------------
	// registers
	// -----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			r <= '0;
			r.mode <= `DHW_MODE_RST;
			r.chipSelN <= 1'b1;
			r.writeStrobeN <= 1'b1;
			r.state <= HS_IDLE;
		end else begin
			r <= next_r;
		end
	end

	assign pready = r.pready;
	assign prdata = r.prdata;
	assign pslverr = r.pslverr;
	assign link.hostSclOut = 1'b0;
	assign link.hostSclOe = r.sclOe;
	assign link.hostSdaOut = 1'b0;
	assign link.hostSdaOe = r.sdaOe;
	assign link.chipSelN = r.chipSelN;
	assign link.writeStrobeN = r.writeStrobeN;
	assign link.interfaceSelect = r.mode[0];
	assign link.protocolSelect = r.mode[1];
	assign link.targetSelHi = r.tsel[1];
	assign link.targetSelLo = r.tsel[0];
	assign link.channelAddress = r.chan;
	assign link.parallelWord = r.word;
endmodule : dhw_host

// ==== core/dhw_if.sv ====
`timescale 1ns/1ps

interface dhw_if;
	logic        hostSclOut;
	logic        hostSclOe;
	logic        hostSdaOut;
	logic        hostSdaOe;
	logic        devSdaOut;
	logic        devSdaOe;
	logic        sclIn;
	logic        sdaIn;
	logic        chipSelN;
	logic        writeStrobeN;
	logic        interfaceSelect;
	logic        protocolSelect;
	logic        targetSelHi;
	logic        targetSelLo;
	logic [5:0]  channelAddress;
	logic [11:0] parallelWord;

	// open-drain wires with pull-ups: any enabled low driver wins
	assign sclIn = ~(hostSclOe & ~hostSclOut);
	assign sdaIn = ~((hostSdaOe & ~hostSdaOut) | (devSdaOe & ~devSdaOut));

	modport dev (
		input  sclIn, sdaIn, chipSelN, writeStrobeN, interfaceSelect,
		input  protocolSelect, targetSelHi, targetSelLo, channelAddress,
		input  parallelWord,
		output devSdaOut, devSdaOe
	);

	modport host (
		input  sclIn, sdaIn,
		output hostSclOut, hostSclOe, hostSdaOut, hostSdaOe, chipSelN,
		output writeStrobeN, interfaceSelect, protocolSelect, targetSelHi,
		output targetSelLo, channelAddress, parallelWord
	);
endinterface : dhw_if

// ==== core/dhw_pkg.sv ====
package dhw_pkg;

	typedef enum logic [1:0] {
		DS_IDLE = 2'b00,
		DS_RECV = 2'b01,
		DS_ACK  = 2'b10,
		DS_SKIP = 2'b11
	} dhw_dstate_t;

	typedef enum logic [1:0] {
		PH_ADDR = 2'b00,
		PH_PTR  = 2'b01,
		PH_DHI  = 2'b10,
		PH_DLO  = 2'b11
	} dhw_phase_t;

	typedef enum logic [1:0] {
		HS_IDLE = 2'b00,
		HS_SLOT = 2'b01,
		HS_PAR  = 2'b10
	} dhw_hstate_t;

	typedef enum logic [1:0] {
		SK_START = 2'b00,
		SK_BIT   = 2'b01,
		SK_STOP  = 2'b10
	} dhw_slot_t;

	typedef struct packed {
		logic        scl;
		logic        sda;
		logic        chipSelN;
		logic        writeStrobeN;
		logic        interfaceSelect;
		logic        protocolSelect;
		logic        targetSelHi;
		logic        targetSelLo;
		logic [5:0]  channelAddress;
		logic [11:0] parallelWord;
	} dhw_pins_t;

	typedef struct packed {
		dhw_pins_t   s1;
		dhw_pins_t   s2;
		dhw_pins_t   s3;
		dhw_pins_t   flt;
		dhw_pins_t   old;
		dhw_dstate_t state;
		dhw_phase_t  phase;
		logic [3:0]  bitCnt;
		logic [7:0]  shift;
		logic [7:0]  hiByte;
		logic [5:0]  chan;
		logic        burst;
		logic        sdaOe;
		logic        wrStrobe;
		logic [5:0]  wrChan;
		logic [1:0]  wrTarget;
		logic [11:0] wrWord;
		logic        toggleOk;
	} dhw_dev_t;

	typedef struct packed {
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
		logic [1:0]  mode;
		dhw_hstate_t state;
		dhw_slot_t   kind;
		logic [1:0]  q;
		logic [7:0]  qcnt;
		logic [3:0]  bitIdx;
		logic [8:0]  shift;
		logic        doStop;
		logic        nack;
		logic        sclOe;
		logic        sdaOe;
		logic        chipSelN;
		logic        writeStrobeN;
		logic [5:0]  chan;
		logic [1:0]  tsel;
		logic [11:0] word;
		logic [3:0]  sdaSync;
	} dhw_host_t;

endpackage : dhw_pkg

// ==== core/dhw_regs.svh ====
`ifndef DHW_REGS_SVH
`define DHW_REGS_SVH

// -----------------------------------------------------------------
// two-wire addressing and framing
// -----------------------------------------------------------------
`define DHW_ADDR_FIXED  5'h15
`define DHW_BURST_PTR   8'hFF
`define DHW_LAST_CHAN   6'h27
`define DHW_BYTE_BITS   4'h8
// first data byte: target select on top, word bits 11..8 at the bottom
`define DHW_TSEL_HI_BIT 7
`define DHW_TSEL_LO_BIT 6
`define DHW_WHI_MSB     3

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define DHW_CLK_NS      5
`define DHW_SCL_NS      2500
`define DHW_QTR_CYC     (((`DHW_SCL_NS / 4) + `DHW_CLK_NS - 1) / `DHW_CLK_NS)
`define DHW_PAR_NS      40
`define DHW_PAR_CYC     ((`DHW_PAR_NS + `DHW_CLK_NS - 1) / `DHW_CLK_NS)

// -----------------------------------------------------------------
// controller registers
// -----------------------------------------------------------------
`define DHW_OFS_CMD     12'h000
`define DHW_OFS_PAR     12'h004
`define DHW_OFS_STAT    12'h008
`define DHW_OFS_MODE    12'h00C
`define DHW_CMD_START   8
`define DHW_CMD_STOP    9
`define DHW_PAR_CHAN    12
`define DHW_PAR_TSEL    18
`define DHW_STAT_BUSY   0
`define DHW_STAT_NACK   1
`define DHW_MODE_RST    2'h3

`endif

// ==== verif/dac_host_write_interface_bench.sv ====
`timescale 1ns/1ps

module dac_host_write_interface_bench;
	import dhw_pkg::*;
	logic        clk, nrst, psel, penable, pwrite, pready, pslverr, err;
	logic        wrStrobe, burstActive, toggleOk;
	logic        strapHi, strapLo;
	logic [11:0] paddr, wrWord;
	logic [31:0] pwdata, prdata, rd;
	logic [5:0]  wrChan;
	logic [1:0]  wrTarget;
	logic [19:0] got[$];
	int          miscompares, compares;
	// rows: {channel, target select, word}, expected back unchanged
	logic [19:0] rows [4] = '{20'h00001, 20'h9FFFF, 20'h51A5A, 20'h325A5};

	dhw_if link();
	dhw_host u_dhw_host (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .link(link));
	dhw_device u_dhw_device (.clk(clk), .nrst(nrst), .strapBitHi(strapHi),
		.strapBitLo(strapLo),
		.wrStrobe(wrStrobe), .wrChan(wrChan), .wrTarget(wrTarget), .wrWord(wrWord),
		.burstActive(burstActive), .toggleOk(toggleOk), .link(link));
	dhw_properties u_dhw_properties (.clk(clk), .nrst(nrst), .sclIn(link.sclIn),
		.sdaIn(link.sdaIn), .devSdaOe(link.devSdaOe), .chipSelN(link.chipSelN),
		.writeStrobeN(link.writeStrobeN), .interfaceSelect(link.interfaceSelect),
		.protocolSelect(link.protocolSelect), .targetSelHi(link.targetSelHi),
		.targetSelLo(link.targetSelLo), .channelAddress(link.channelAddress),
		.parallelWord(link.parallelWord), .wrStrobe(wrStrobe), .wrChan(wrChan),
		.wrTarget(wrTarget), .wrWord(wrWord), .burstActive(burstActive),
		.toggleOk(toggleOk));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	always @(posedge clk) if (wrStrobe === 1'b1) got.push_back({wrChan, wrTarget, wrWord});

	task end_of_test;
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_of_test

	task cmp(input logic [31:0] e, input logic [31:0] a);
		compares++;
		if (a !== e) begin
			miscompares++;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, e, a);
		end
	endtask : cmp

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// poll busy; a byte slot is thousands of cycles, so the bound is generous
	task idle_wait;
		for (int i = 0; i < 4000; i++) begin
			apb(1'b0, 12'h008, 32'h0);
			if (rd[0] === 1'b0) break;
		end
	endtask : idle_wait

	task sendb(input logic [7:0] b, input logic st, input logic sp, input logic nk);
		apb(1'b1, 12'h000, {22'h0, sp, st, b});
		idle_wait();
		cmp({31'h0, nk}, {31'h0, rd[1]});
	endtask : sendb

	task chk_wr(input logic [19:0] e);
		cmp({12'h0, e}, got.size() ? {12'h0, got.pop_front()} : 32'hFFFFFFFF);
	endtask : chk_wr

	task pair(input logic [19:0] r, input logic sp);
		sendb({r[13:12], 2'b00, r[11:8]}, 1'b0, 1'b0, 1'b0);
		sendb(r[7:0], 1'b0, sp, 1'b0);
	endtask : pair

	initial begin
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		strapHi = 1'b1;
		strapLo = 1'b0;
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		apb(1'b0, 12'h00C, 32'h0);
		cmp(32'h3, rd);
		apb(1'b0, 12'h010, 32'h0);
		cmp(32'h1, {31'h0, err});
		apb(1'b1, 12'h00C, 32'h0);
		foreach (rows[i]) begin
			apb(1'b1, 12'h004, {12'h0, rows[i][13:12], rows[i][19:14], rows[i][11:0]});
			idle_wait();
			chk_wr(rows[i]);
		end
		// strobes while interface select is high (mode 1, serial side still off) must be dropped
		apb(1'b1, 12'h00C, 32'h1);
		apb(1'b1, 12'h004, {12'h0, 2'h3, 6'h01, 12'h0F0});
		idle_wait();
		cmp(32'h0, got.size());
		apb(1'b1, 12'h00C, 32'h3);
		repeat (10) @(posedge clk);
		sendb(8'hAC, 1'b1, 1'b0, 1'b0);
		sendb(8'h05, 1'b0, 1'b0, 1'b0);
		pair(20'h15123, 1'b0);
		chk_wr(20'h15123);
		sendb(8'h27, 1'b0, 1'b0, 1'b0);
		pair(rows[1], 1'b1);
		chk_wr(rows[1]);
		sendb(8'hAC, 1'b1, 1'b0, 1'b0);
		sendb(8'hFF, 1'b0, 1'b0, 1'b0);
		pair(20'h02789, 1'b0);
		chk_wr(20'h02789);
		pair(20'h07ABC, 1'b0);
		chk_wr(20'h07ABC);
		cmp(32'h1, {31'h0, burstActive});
		cmp(32'h0, {31'h0, toggleOk});
		// stop in the middle of a pair: nothing written, burst over
		sendb(8'h4A, 1'b0, 1'b1, 1'b0);
		cmp(32'h0, {31'h0, burstActive});
		cmp(32'h1, {31'h0, toggleOk});
		cmp(32'h0, got.size());
		sendb(8'hAE, 1'b1, 1'b1, 1'b1);
		sendb(8'hAD, 1'b1, 1'b1, 1'b1);
		cmp(32'h0, got.size());
		// straps are live: with both high the other address answers
		strapLo <= 1'b1;
		sendb(8'hAE, 1'b1, 1'b1, 1'b0);
		end_of_test();
	end

	initial begin
		// a clean run needs roughly 82000 cycles
		repeat (98000) @(posedge clk);
		miscompares++;
		end_of_test();
	end
endmodule : dac_host_write_interface_bench

// ==== verif/dhw_properties.sv ====
`timescale 1ns/1ps

module dhw_properties (
	// clock and reset
	input wire logic        clk,
	input wire logic        nrst,
	// link wires
	input wire logic        sclIn,
	input wire logic        sdaIn,
	input wire logic        devSdaOe,
	input wire logic        chipSelN,
	input wire logic        writeStrobeN,
	input wire logic        interfaceSelect,
	input wire logic        protocolSelect,
	input wire logic        targetSelHi,
	input wire logic        targetSelLo,
	input wire logic [5:0]  channelAddress,
	input wire logic [11:0] parallelWord,
	// device results
	input wire logic        wrStrobe,
	input wire logic [5:0]  wrChan,
	input wire logic [1:0]  wrTarget,
	input wire logic [11:0] wrWord,
	input wire logic        burstActive,
	input wire logic        toggleOk
);
	logic [3:0] csHighCnt;
	logic [3:0] offCnt;
	logic [5:0] burstCnt;

	// csHighCnt and offCnt saturate at 15: how long the select pins have stood; burstCnt counts writes during a burst
	always_ff @(posedge clk) begin
		if (!nrst) begin
			csHighCnt <= 4'h0;
			offCnt    <= 4'h0;
			burstCnt  <= 6'h0;
		end else begin
			csHighCnt <= !chipSelN ? 4'h0 : csHighCnt + {3'h0, csHighCnt != 4'hF};
			offCnt    <= (interfaceSelect && protocolSelect) ? 4'h0 :
				offCnt + {3'h0, offCnt != 4'hF};
			burstCnt  <= !burstActive ? 6'h0 : burstCnt + {5'h0, wrStrobe};
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence parEdge;
		$rose(writeStrobeN) && !chipSelN && !interfaceSelect;
	endsequence
	sequence parLoad;
		wrStrobe && wrWord == parallelWord && wrChan == channelAddress
			&& wrTarget == {targetSelHi, targetSelLo};
	endsequence
	sequence stopSeen;
		sclIn && $past(sclIn) && $rose(sdaIn);
	endsequence

	chk_par_latch: assert property (parEdge |-> ##[2:10] parLoad)
		else $error("parallel strobe edge not loaded");
	chk_strobe_pulse: assert property (wrStrobe |=> !wrStrobe)
		else $error("write pulse longer than one cycle");
	chk_par_cs_gate: assert property ((wrStrobe && !interfaceSelect) |-> csHighCnt < 4'h8)
		else $error("parallel write without chip select");
	chk_toggle_burst: assert property (toggleOk != burstActive)
		else $error("toggle allowed during burst");
	chk_stop_clears: assert property (stopSeen |-> ##[1:12] !burstActive)
		else $error("burst survives stop");
	chk_serial_off: assert property (offCnt >= 4'h8 |-> !devSdaOe)
		else $error("serial answer while deselected");
	chk_ack_scl_low: assert property ($changed(devSdaOe) |-> !sclIn)
		else $error("data line moved while clock high");
	chk_burst_order: assert property ((wrStrobe && burstActive) |->
		wrChan == burstCnt && wrChan <= 6'h27)
		else $error("burst channel out of order");
endmodule : dhw_properties
